// >>> hdl/scmsr_params.svh
// Constants of the system configuration and model register bank.
// Assumes inclusion by scmsr_pkg, scmsr_bank and tb only.
`ifndef SCMSR_PARAMS_SVH
`define SCMSR_PARAMS_SVH

// Register addresses as seen by the register-read and register-write instructions
`define SCMSR_ADDR_CFG         32'hc001_0010
`define SCMSR_ADDR_CALL_LEGACY 32'h0000_0a00
`define SCMSR_ADDR_CALL_LONG   32'h0000_0a01
`define SCMSR_ADDR_CALL_COMPAT 32'h0000_0a02
`define SCMSR_ADDR_FLAG_MASK   32'h0000_0a03
`define SCMSR_ADDR_F_BASE      32'h0000_0a04
`define SCMSR_ADDR_G_BASE      32'h0000_0a05
`define SCMSR_ADDR_KSWAP_BASE  32'h0000_0a06
`define SCMSR_ADDR_ENT_CS      32'h0000_0a07
`define SCMSR_ADDR_ENT_SP      32'h0000_0a08
`define SCMSR_ADDR_ENT_IP      32'h0000_0a09
`define SCMSR_ADDR_CAP         32'h0000_0a10
`define SCMSR_ADDR_DEF_TYPE    32'h0000_0a11
`define SCMSR_ADDR_PAGE_TBL    32'h0000_0a12
`define SCMSR_ADDR_TOP1        32'h0000_0a13
`define SCMSR_ADDR_TOP2        32'h0000_0a14
`define SCMSR_ADDR_VAR_FIRST   32'h0000_0a20
`define SCMSR_ADDR_VAR_LAST    32'h0000_0a2f
`define SCMSR_ADDR_FIX_FIRST   32'h0000_0a30
`define SCMSR_ADDR_FIX_LAST    32'h0000_0a37

// System configuration fields
`define SCMSR_BIT_FIX_EN       18
`define SCMSR_BIT_FIX_MOD      19
`define SCMSR_BIT_VAR_IO       20
`define SCMSR_BIT_TOP2_EN      21
`define SCMSR_CFG_WMASK        32'h003c_0000
`define SCMSR_CFG_RESET        32'h0000_0000

// Memory typing layout, register reset value and kernel privilege level
`define SCMSR_FIX_ATTR_MASK    64'h1818_1818_1818_1818
`define SCMSR_VAR_VALID_BIT    11
`define SCMSR_CAP_VALUE        64'h0000_0000_0000_0108
`define SCMSR_FOUR_GB          48'h0001_0000_0000
`define SCMSR_REG_RESET        64'h0000_0000_0000_0000
`define SCMSR_CPL_KERNEL       2'h0

`endif

// >>> hdl/scmsr_pkg.sv
// Types shared by the model register bank.
// Assumes scmsr_params.svh sits on the include path.
`include "scmsr_params.svh"

package scmsr_pkg;

  // Register classes reached by the register instructions
  typedef enum logic [4:0] {
    SCMSR_K_NONE, SCMSR_K_CFG, SCMSR_K_CALL_LEGACY, SCMSR_K_CALL_LONG,
    SCMSR_K_CALL_COMPAT, SCMSR_K_FLAG_MASK, SCMSR_K_F_BASE, SCMSR_K_G_BASE,
    SCMSR_K_KSWAP, SCMSR_K_ENT_CS, SCMSR_K_ENT_SP, SCMSR_K_ENT_IP, SCMSR_K_CAP,
    SCMSR_K_DEF_TYPE, SCMSR_K_PAGE_TBL, SCMSR_K_TOP1, SCMSR_K_TOP2, SCMSR_K_VAR_BASE,
    SCMSR_K_VAR_MASK, SCMSR_K_FIX
  } scmsr_kind_e;

  // Decoded register address
  typedef struct packed {
    scmsr_kind_e kind;
    logic [2:0]  idx;
  } scmsr_dec_s;

endpackage : scmsr_pkg

// >>> hdl/scmsr_bank.sv
// Model register bank: system configuration, linkage and memory typing registers.
// Assumes the core issues register instructions on the access port, one per cycle,
// and that all inputs come from logic on mclk_in.
`timescale 1ns/1ps
`include "scmsr_params.svh"

module scmsr_bank
  import scmsr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Register instruction port
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [63:0] wdata_in,
  input  wire logic [1:0]  cpl_in,
  output logic             ack_out,
  output logic             gp_fault_out,
  output logic [63:0]      rdata_out,
  // Processor mode and base swap
  input  wire logic        long_active_in,
  input  wire logic        code_long_in,
  input  wire logic        swap_in,
  // Linkage outputs
  output logic [63:0]      call_target_out,
  output logic [63:0]      call_flag_mask_out,
  output logic [63:0]      f_seg_base_out,
  output logic [63:0]      g_seg_base_out,
  output logic             entry_valid_out,
  output logic [63:0]      entry_cs_out,
  output logic [63:0]      entry_sp_out,
  output logic [63:0]      entry_ip_out,
  // Memory type lookup
  input  wire logic [47:0] phys_addr_in,
  input  wire logic [2:0]  page_attr_in,
  output logic [7:0]       mem_type_out,
  output logic             read_to_dram_out,
  output logic             write_to_dram_out,
  output logic             mmio_out,
  output logic             io_range_enable_out,
  output logic [7:0]       page_type_out
);

  // Address decode used by both read and write paths
  function automatic scmsr_dec_s scmsr_decode(input logic [31:0] a);
    scmsr_dec_s d;
    d.kind = SCMSR_K_NONE;
    d.idx  = a[3:1];
    if (a == `SCMSR_ADDR_CFG) begin
      d.kind = SCMSR_K_CFG;
    end else if (a == `SCMSR_ADDR_CALL_LEGACY) begin
      d.kind = SCMSR_K_CALL_LEGACY;
    end else if (a == `SCMSR_ADDR_CALL_LONG) begin
      d.kind = SCMSR_K_CALL_LONG;
    end else if (a == `SCMSR_ADDR_CALL_COMPAT) begin
      d.kind = SCMSR_K_CALL_COMPAT;
    end else if (a == `SCMSR_ADDR_FLAG_MASK) begin
      d.kind = SCMSR_K_FLAG_MASK;
    end else if (a == `SCMSR_ADDR_F_BASE) begin
      d.kind = SCMSR_K_F_BASE;
    end else if (a == `SCMSR_ADDR_G_BASE) begin
      d.kind = SCMSR_K_G_BASE;
    end else if (a == `SCMSR_ADDR_KSWAP_BASE) begin
      d.kind = SCMSR_K_KSWAP;
    end else if (a == `SCMSR_ADDR_ENT_CS) begin
      d.kind = SCMSR_K_ENT_CS;
    end else if (a == `SCMSR_ADDR_ENT_SP) begin
      d.kind = SCMSR_K_ENT_SP;
    end else if (a == `SCMSR_ADDR_ENT_IP) begin
      d.kind = SCMSR_K_ENT_IP;
    end else if (a == `SCMSR_ADDR_CAP) begin
      d.kind = SCMSR_K_CAP;
    end else if (a == `SCMSR_ADDR_DEF_TYPE) begin
      d.kind = SCMSR_K_DEF_TYPE;
    end else if (a == `SCMSR_ADDR_PAGE_TBL) begin
      d.kind = SCMSR_K_PAGE_TBL;
    end else if (a == `SCMSR_ADDR_TOP1) begin
      d.kind = SCMSR_K_TOP1;
    end else if (a == `SCMSR_ADDR_TOP2) begin
      d.kind = SCMSR_K_TOP2;
    end else if (a >= `SCMSR_ADDR_VAR_FIRST && a <= `SCMSR_ADDR_VAR_LAST) begin
      d.kind = a[0] ? SCMSR_K_VAR_MASK : SCMSR_K_VAR_BASE;
    end else if (a >= `SCMSR_ADDR_FIX_FIRST && a <= `SCMSR_ADDR_FIX_LAST) begin
      d.kind = SCMSR_K_FIX;
      d.idx  = a[2:0];
    end
    return d;
  endfunction : scmsr_decode

  // Variable range match on 4 Kbyte granules
  function automatic logic scmsr_var_hit(input logic [47:0] pa, input logic [63:0] base,
                                         input logic [63:0] mask);
    return mask[`SCMSR_VAR_VALID_BIT]
           && ((pa[47:12] & mask[47:12]) == (base[47:12] & mask[47:12]));
  endfunction : scmsr_var_hit

  // Register state
  logic [31:0] cfg;
  logic [63:0] call_legacy, call_long, call_compat, flag_mask;
  logic [63:0] f_base, g_base, kswap_base, ent_cs, ent_sp, ent_ip;
  logic [63:0] def_type, page_tbl, top1, top2;
  logic [63:0] var_base [8], var_mask [8], fix_type [8];
  logic [31:0] next_cfg;
  logic [63:0] next_call_legacy, next_call_long, next_call_compat, next_flag_mask;
  logic [63:0] next_f_base, next_g_base, next_kswap_base, next_ent_cs, next_ent_sp, next_ent_ip;
  logic [63:0] next_def_type, next_page_tbl, next_top1, next_top2;
  logic [63:0] next_var_base [8], next_var_mask [8], next_fix_type [8];
  // Answer and lookup state
  logic        next_ack, next_fault, next_entry_valid, next_rd_dram, next_wr_dram, next_mmio;
  logic [63:0] next_rdata, next_call_target, next_call_mask, next_f_seg, next_g_seg;
  logic [7:0]  next_mem_type, next_page_type;

  scmsr_dec_s  dec;
  logic        do_rd, do_wr, var_any, in_top1, in_top2;
  logic [7:0]  fix_byte, var_type;
  logic [63:0] fix_w;

  // Next-state computation for registers, answers and lookups
  always_comb begin
    next_cfg         = cfg;
    next_call_legacy = call_legacy;
    next_call_long   = call_long;
    next_call_compat = call_compat;
    next_flag_mask   = flag_mask;
    next_f_base      = f_base;
    next_g_base      = g_base;
    next_kswap_base  = kswap_base;
    next_ent_cs      = ent_cs;
    next_ent_sp      = ent_sp;
    next_ent_ip      = ent_ip;
    next_def_type    = def_type;
    next_page_tbl    = page_tbl;
    next_top1        = top1;
    next_top2        = top2;
    next_var_base    = var_base;
    next_var_mask    = var_mask;
    next_fix_type    = fix_type;
    next_rdata       = rdata_out;
    dec = scmsr_decode(addr_in);
    // Only the instruction port and swap_in reach the registers; privilege and address checked
    next_fault = req_in && (cpl_in != `SCMSR_CPL_KERNEL || dec.kind == SCMSR_K_NONE
                 || (wr_in && dec.kind == SCMSR_K_CAP));
    next_ack   = req_in && !next_fault;
    do_rd      = next_ack && !wr_in;
    do_wr      = next_ack && wr_in;
    // Fixed-range write keeps DRAM attribute bits unless modification is enabled
    fix_w = cfg[`SCMSR_BIT_FIX_MOD] ? wdata_in
          : ((wdata_in & ~`SCMSR_FIX_ATTR_MASK)
             | (fix_type[dec.idx] & `SCMSR_FIX_ATTR_MASK));
    if (do_rd) begin
      case (dec.kind)
        SCMSR_K_CFG:         next_rdata = {32'h0, cfg & `SCMSR_CFG_WMASK};
        SCMSR_K_CALL_LEGACY: next_rdata = call_legacy;
        SCMSR_K_CALL_LONG:   next_rdata = call_long;
        SCMSR_K_CALL_COMPAT: next_rdata = call_compat;
        SCMSR_K_FLAG_MASK:   next_rdata = flag_mask;
        SCMSR_K_F_BASE:      next_rdata = f_base;
        SCMSR_K_G_BASE:      next_rdata = g_base;
        SCMSR_K_KSWAP:       next_rdata = kswap_base;
        SCMSR_K_ENT_CS:      next_rdata = ent_cs;
        SCMSR_K_ENT_SP:      next_rdata = ent_sp;
        SCMSR_K_ENT_IP:      next_rdata = ent_ip;
        SCMSR_K_CAP:         next_rdata = `SCMSR_CAP_VALUE;
        SCMSR_K_DEF_TYPE:    next_rdata = def_type;
        SCMSR_K_PAGE_TBL:    next_rdata = page_tbl;
        SCMSR_K_TOP1:        next_rdata = top1;
        SCMSR_K_TOP2:        next_rdata = top2;
        SCMSR_K_VAR_BASE:    next_rdata = var_base[dec.idx];
        SCMSR_K_VAR_MASK:    next_rdata = var_mask[dec.idx];
        SCMSR_K_FIX:         next_rdata = cfg[`SCMSR_BIT_FIX_MOD] ? fix_type[dec.idx]
                                        : (fix_type[dec.idx] & ~`SCMSR_FIX_ATTR_MASK);
        default:             next_rdata = `SCMSR_REG_RESET;
      endcase
    end
    if (do_wr) begin
      case (dec.kind)
        SCMSR_K_CFG:         next_cfg = wdata_in[31:0] & `SCMSR_CFG_WMASK;
        SCMSR_K_CALL_LEGACY: next_call_legacy = wdata_in;
        SCMSR_K_CALL_LONG:   next_call_long = wdata_in;
        SCMSR_K_CALL_COMPAT: next_call_compat = wdata_in;
        SCMSR_K_FLAG_MASK:   next_flag_mask = wdata_in;
        SCMSR_K_F_BASE:      next_f_base = wdata_in;
        SCMSR_K_G_BASE:      next_g_base = wdata_in;
        SCMSR_K_KSWAP:       next_kswap_base = wdata_in;
        SCMSR_K_ENT_CS:      next_ent_cs = wdata_in;
        SCMSR_K_ENT_SP:      next_ent_sp = wdata_in;
        SCMSR_K_ENT_IP:      next_ent_ip = wdata_in;
        SCMSR_K_DEF_TYPE:    next_def_type = wdata_in;
        SCMSR_K_PAGE_TBL:    next_page_tbl = wdata_in;
        SCMSR_K_TOP1:        next_top1 = wdata_in;
        SCMSR_K_TOP2:        next_top2 = wdata_in;
        SCMSR_K_VAR_BASE:    next_var_base[dec.idx] = wdata_in;
        SCMSR_K_VAR_MASK:    next_var_mask[dec.idx] = wdata_in;
        SCMSR_K_FIX:         next_fix_type[dec.idx] = fix_w;
        default:             next_cfg = cfg;
      endcase
    end
    // Base swap exchanges both registers in one edge, overriding any same-cycle write to either
    if (swap_in) begin
      next_g_base     = kswap_base;
      next_kswap_base = g_base;
    end
    // Fast call linkage by operating mode
    next_call_target = !long_active_in ? call_legacy
                     : (code_long_in ? call_long : call_compat);
    next_call_mask   = long_active_in ? flag_mask : `SCMSR_REG_RESET;
    next_f_seg       = (long_active_in && code_long_in) ? f_base : `SCMSR_REG_RESET;
    next_g_seg       = (long_active_in && code_long_in) ? g_base : `SCMSR_REG_RESET;
    next_entry_valid = !long_active_in;
    // Memory type: fixed below 1 Mbyte, then first variable match, then default
    fix_byte = fix_type[phys_addr_in[19:17]][{phys_addr_in[16:14], 3'h0} +: 8];
    var_any  = 1'b0;
    var_type = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (scmsr_var_hit(phys_addr_in, var_base[i], var_mask[i])) begin
        var_any  = 1'b1;
        var_type = var_base[i][7:0];
      end
    end
    next_rd_dram = 1'b0;
    next_wr_dram = 1'b0;
    if (phys_addr_in[47:20] == 28'h000_0000) begin
      next_mem_type = {5'h00, fix_byte[2:0]};
      next_rd_dram  = cfg[`SCMSR_BIT_FIX_EN] && fix_byte[4];
      next_wr_dram  = cfg[`SCMSR_BIT_FIX_EN] && fix_byte[3];
    end else if (var_any) begin
      next_mem_type = var_type;
    end else begin
      next_mem_type = def_type[7:0];
    end
    // DRAM below the enabled limits, everything else above them is I/O
    in_top1   = phys_addr_in < top1[47:0];
    in_top2   = cfg[`SCMSR_BIT_TOP2_EN] && phys_addr_in >= `SCMSR_FOUR_GB
                && phys_addr_in < top2[47:0];
    next_mmio = cfg[`SCMSR_BIT_VAR_IO] && !(in_top1 || in_top2);
    next_page_type = page_tbl[{page_attr_in, 3'h0} +: 8];
  end

  // Register update with synchronous reset
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cfg                <= `SCMSR_CFG_RESET;
      call_legacy        <= `SCMSR_REG_RESET;
      call_long          <= `SCMSR_REG_RESET;
      call_compat        <= `SCMSR_REG_RESET;
      flag_mask          <= `SCMSR_REG_RESET;
      f_base             <= `SCMSR_REG_RESET;
      g_base             <= `SCMSR_REG_RESET;
      kswap_base         <= `SCMSR_REG_RESET;
      ent_cs             <= `SCMSR_REG_RESET;
      ent_sp             <= `SCMSR_REG_RESET;
      ent_ip             <= `SCMSR_REG_RESET;
      def_type           <= `SCMSR_REG_RESET;
      page_tbl           <= `SCMSR_REG_RESET;
      top1               <= `SCMSR_REG_RESET;
      top2               <= `SCMSR_REG_RESET;
      for (int i = 0; i < 8; i++) begin
        var_base[i] <= `SCMSR_REG_RESET;
        var_mask[i] <= `SCMSR_REG_RESET;
        fix_type[i] <= `SCMSR_REG_RESET;
      end
      ack_out            <= 1'b0;
      gp_fault_out       <= 1'b0;
      rdata_out          <= `SCMSR_REG_RESET;
      call_target_out    <= `SCMSR_REG_RESET;
      call_flag_mask_out <= `SCMSR_REG_RESET;
      f_seg_base_out     <= `SCMSR_REG_RESET;
      g_seg_base_out     <= `SCMSR_REG_RESET;
      entry_valid_out    <= 1'b0;
      mem_type_out       <= 8'h00;
      read_to_dram_out   <= 1'b0;
      write_to_dram_out  <= 1'b0;
      mmio_out           <= 1'b0;
      page_type_out      <= 8'h00;
    end else begin
      cfg                <= next_cfg;
      call_legacy        <= next_call_legacy;
      call_long          <= next_call_long;
      call_compat        <= next_call_compat;
      flag_mask          <= next_flag_mask;
      f_base             <= next_f_base;
      g_base             <= next_g_base;
      kswap_base         <= next_kswap_base;
      ent_cs             <= next_ent_cs;
      ent_sp             <= next_ent_sp;
      ent_ip             <= next_ent_ip;
      def_type           <= next_def_type;
      page_tbl           <= next_page_tbl;
      top1               <= next_top1;
      top2               <= next_top2;
      var_base           <= next_var_base;
      var_mask           <= next_var_mask;
      fix_type           <= next_fix_type;
      ack_out            <= next_ack;
      gp_fault_out       <= next_fault;
      rdata_out          <= next_rdata;
      call_target_out    <= next_call_target;
      call_flag_mask_out <= next_call_mask;
      f_seg_base_out     <= next_f_seg;
      g_seg_base_out     <= next_g_seg;
      entry_valid_out    <= next_entry_valid;
      mem_type_out       <= next_mem_type;
      read_to_dram_out   <= next_rd_dram;
      write_to_dram_out  <= next_wr_dram;
      mmio_out           <= next_mmio;
      page_type_out      <= next_page_type;
    end
  end

  // Fast entry linkage and range enable straight from their registers
  assign entry_cs_out        = ent_cs;
  assign entry_sp_out        = ent_sp;
  assign entry_ip_out        = ent_ip;
  assign io_range_enable_out = cfg[`SCMSR_BIT_VAR_IO];

endmodule : scmsr_bank

// >>> verification/scmsr_bank_properties.sv
// Port checker for the model register bank.
// Assumes one clock mclk_in and the synchronous active-low reset nrst_in.
`timescale 1ns/1ps
module scmsr_bank_props (
  // Clock, reset and register port
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        req_in,
  input wire logic        wr_in,
  input wire logic [31:0] addr_in,
  input wire logic [63:0] wdata_in,
  input wire logic [1:0]  cpl_in,
  input wire logic        ack_out,
  input wire logic        gp_fault_out,
  input wire logic [63:0] rdata_out,
  // Mode and lookup
  input wire logic        long_active_in,
  input wire logic        code_long_in,
  input wire logic [63:0] call_flag_mask_out,
  input wire logic [63:0] f_seg_base_out,
  input wire logic [63:0] g_seg_base_out,
  input wire logic        entry_valid_out,
  input wire logic [47:0] phys_addr_in,
  input wire logic        read_to_dram_out,
  input wire logic        write_to_dram_out,
  input wire logic        mmio_out,
  input wire logic        io_range_enable_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  // Privileged access to the configuration register
  logic cfg_hit;
  assign cfg_hit = req_in && cpl_in == 2'h0 && addr_in == 32'hc001_0010;

  property p_cfg_ack; cfg_hit |=> ack_out && !gp_fault_out; endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("config access refused");
  property p_unpriv; req_in && cpl_in != 2'h0 |=> gp_fault_out && !ack_out; endproperty
  a_unpriv: assert property (p_unpriv) else $error("user access not faulted");
  property p_idle; !req_in |=> !ack_out && !gp_fault_out; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_cfg_rd; cfg_hit && !wr_in |=> (rdata_out & ~64'h3c_0000) == 64'h0; endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("reserved config bits not zero");
  property p_io_en; cfg_hit && wr_in |=> io_range_enable_out == $past(wdata_in[20]); endproperty
  a_io_en: assert property (p_io_en) else $error("io enable does not follow write");
  property p_mmio_off; !io_range_enable_out |=> !mmio_out; endproperty
  a_mmio_off: assert property (p_mmio_off) else $error("mmio while limits disabled");
  property p_mask; !long_active_in |=> call_flag_mask_out == 64'h0; endproperty
  a_mask: assert property (p_mask) else $error("flag mask outside long mode");
  property p_base;
    !(long_active_in && code_long_in) |=> f_seg_base_out == 64'h0 && g_seg_base_out == 64'h0;
  endproperty
  a_base: assert property (p_base) else $error("segment base outside 64-bit mode");
  property p_entry; $past(nrst_in) |-> entry_valid_out == !$past(long_active_in); endproperty
  a_entry: assert property (p_entry) else $error("entry valid wrong for mode");
  property p_high; phys_addr_in >= 48'h10_0000 |=> !read_to_dram_out && !write_to_dram_out;
  endproperty
  a_high: assert property (p_high) else $error("dram attribute above 1MB");
  property p_cap; req_in && wr_in && cpl_in == 2'h0 && addr_in == 32'h0a10 |=> gp_fault_out;
  endproperty
  a_cap: assert property (p_cap) else $error("capability write accepted");

  // Main scenarios reached
  c_cfg_wr: cover property (cfg_hit && wr_in);
  c_fault: cover property (gp_fault_out);
  c_mmio: cover property (mmio_out);
endmodule : scmsr_bank_props

bind scmsr_bank scmsr_bank_props u_scmsr_bank_props (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req_in), .wr_in(wr_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .cpl_in(cpl_in), .ack_out(ack_out), .gp_fault_out(gp_fault_out),
  .rdata_out(rdata_out), .long_active_in(long_active_in), .code_long_in(code_long_in),
  .call_flag_mask_out(call_flag_mask_out), .f_seg_base_out(f_seg_base_out),
  .g_seg_base_out(g_seg_base_out), .entry_valid_out(entry_valid_out),
  .phys_addr_in(phys_addr_in), .read_to_dram_out(read_to_dram_out),
  .write_to_dram_out(write_to_dram_out), .mmio_out(mmio_out),
  .io_range_enable_out(io_range_enable_out)
);

// >>> verification/tb.sv
// Self-checking bench for the model register bank.
// Assumes the package, header and bank are compiled first; inputs change on falling edges.
`timescale 1ns/1ps
`include "scmsr_params.svh"
module tb;
  import scmsr_pkg::*;
  localparam logic [31:0] cfg_a = 32'hc001_0010;
  logic        mclk_in, nrst_in, req_in, wr_in, long_active_in, code_long_in, swap_in;
  logic        ack_out, gp_fault_out, entry_valid_out, read_to_dram_out, write_to_dram_out;
  logic        mmio_out, io_range_enable_out;
  logic [1:0]  cpl_in;
  logic [2:0]  page_attr_in;
  logic [7:0]  mem_type_out, page_type_out;
  logic [31:0] addr_in;
  logic [47:0] phys_addr_in;
  logic [63:0] wdata_in, rdata_out, call_target_out, call_flag_mask_out, f_seg_base_out;
  logic [63:0] g_seg_base_out, entry_cs_out, entry_sp_out, entry_ip_out;
  int          bad_count = 0;
  int          compares = 0;

  scmsr_bank u_scmsr_bank (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req_in),
    .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in), .cpl_in(cpl_in),
    .ack_out(ack_out), .gp_fault_out(gp_fault_out), .rdata_out(rdata_out),
    .long_active_in(long_active_in), .code_long_in(code_long_in), .swap_in(swap_in),
    .call_target_out(call_target_out), .call_flag_mask_out(call_flag_mask_out),
    .f_seg_base_out(f_seg_base_out), .g_seg_base_out(g_seg_base_out),
    .entry_valid_out(entry_valid_out), .entry_cs_out(entry_cs_out),
    .entry_sp_out(entry_sp_out), .entry_ip_out(entry_ip_out), .phys_addr_in(phys_addr_in),
    .page_attr_in(page_attr_in), .mem_type_out(mem_type_out),
    .read_to_dram_out(read_to_dram_out), .write_to_dram_out(write_to_dram_out),
    .mmio_out(mmio_out), .io_range_enable_out(io_range_enable_out),
    .page_type_out(page_type_out));

  // Clock at 50 MHz
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // One register instruction, answer judged, then one idle cycle
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d,
                     input logic [1:0] p, input logic ef, output logic [63:0] rd);
    req_in = 1'b1;
    wr_in = w;
    addr_in = a;
    wdata_in = d;
    cpl_in = p;
    @(negedge mclk_in);
    rd = rdata_out;
    chk("answer", {ack_out, gp_fault_out}, ef ? 64'h1 : 64'h2);
    req_in = 1'b0;
    @(negedge mclk_in);
  endtask : acc

  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    logic [63:0] v;
    acc(1'b1, a, d, 2'h0, 1'b0, v);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [63:0] e, input string n);
    logic [63:0] v;
    acc(1'b0, a, 64'h0, 2'h0, 1'b0, v);
    chk(n, v, e);
  endtask : rdc

  // Present a lookup and let the registered outputs settle
  task automatic look(input logic [47:0] pa, input logic [2:0] pt);
    phys_addr_in = pa;
    page_attr_in = pt;
    @(negedge mclk_in);
  endtask : look

  task automatic t_cfg;
    rdc(cfg_a, 64'h0, "cfg reset");
    wr(cfg_a, '1);
    rdc(cfg_a, 64'h3c_0000, "cfg reserved");
    for (int b = 18; b < 22; b++) begin
      wr(cfg_a, 64'h1 << b);
      rdc(cfg_a, 64'h1 << b, "cfg bit");
      chk("io enable", io_range_enable_out, b == 20);
    end
  endtask : t_cfg

  task automatic t_priv;
    logic [63:0] v;
    for (int p = 1; p < 4; p++) acc(1'b1, cfg_a, '1, p[1:0], 1'b1, v);
    rdc(cfg_a, 64'h20_0000, "cfg kept");
    acc(1'b0, 32'h0000_0bff, 64'h0, 2'h0, 1'b1, v);
    acc(1'b1, 32'h0000_0a10, 64'h0, 2'h0, 1'b1, v);
    rdc(32'h0000_0a10, `SCMSR_CAP_VALUE, "capability");
  endtask : t_priv

  task automatic t_link;
    for (int i = 0; i < 10; i++) wr(32'h0000_0a00 + i, 64'h11 * (i + 1));
    for (int m = 0; m < 3; m++) begin
      long_active_in = m != 0;
      code_long_in = m == 1;
      @(negedge mclk_in);
      chk("call target", call_target_out, 64'h11 * (m + 1));
      chk("flag mask", call_flag_mask_out, m != 0 ? 64'h44 : 64'h0);
      chk("f base", f_seg_base_out, m == 1 ? 64'h55 : 64'h0);
      chk("g base", g_seg_base_out, m == 1 ? 64'h66 : 64'h0);
      chk("entry valid", entry_valid_out, m == 0);
    end
    chk("entry cs", entry_cs_out, 64'h88);
    chk("entry sp", entry_sp_out, 64'h99);
    chk("entry ip", entry_ip_out, 64'haa);
    swap_in = 1'b1;
    @(negedge mclk_in);
    swap_in = 1'b0;
    rdc(32'h0000_0a05, 64'h77, "g swapped");
    rdc(32'h0000_0a06, 64'h66, "kernel swapped");
  endtask : t_link

  task automatic t_type;
    wr(32'h0000_0a11, 64'h6);
    wr(32'h0000_0a20, 64'h20_0004);
    wr(32'h0000_0a21, 64'hffff_ffff_f800);
    wr(32'h0000_0a2e, 64'h20_0001);
    wr(32'h0000_0a2f, 64'hffff_ffff_e800);
    look(48'h20_0010, 3'h0);
    chk("pair 0", mem_type_out, 8'h04);
    look(48'h20_1010, 3'h0);
    chk("pair 7", mem_type_out, 8'h01);
    look(48'h20_2010, 3'h0);
    chk("default", mem_type_out, 8'h06);
    wr(32'h0000_0a30, 64'h1e);
    rdc(32'h0000_0a30, 64'h06, "attr frozen");
    wr(cfg_a, 64'h8_0000);
    wr(32'h0000_0a30, 64'h1e);
    rdc(32'h0000_0a30, 64'h1e, "attr written");
    look(48'h0, 3'h0);
    chk("fixed type", mem_type_out, 8'h06);
    chk("dram off", {read_to_dram_out, write_to_dram_out}, 2'h0);
    wr(cfg_a, 64'h4_0000);
    chk("dram on", {read_to_dram_out, write_to_dram_out}, 2'h3);
    rdc(32'h0000_0a30, 64'h06, "attr hidden");
    wr(32'h0000_0a12, 64'h7766_5544_3322_1100);
    for (int i = 0; i < 8; i++) begin
      look(48'h0, i[2:0]);
      chk("page type", page_type_out, 8'h11 * i);
    end
  endtask : t_type

  task automatic t_top;
    wr(32'h0000_0a13, 64'h4000_0000);
    wr(32'h0000_0a14, 64'h2_0000_0000);
    wr(cfg_a, 64'h10_0000);
    look(48'h1000_0000, 3'h0);
    chk("below top", mmio_out, 1'b0);
    look(48'h1_0000_0000, 3'h0);
    chk("top2 off", mmio_out, 1'b1);
    wr(cfg_a, 64'h30_0000);
    chk("top2 on", mmio_out, 1'b0);
    look(48'h8000_0000, 3'h0);
    chk("above top", mmio_out, 1'b1);
    wr(cfg_a, 64'h0);
    chk("limits off", mmio_out, 1'b0);
  endtask : t_top

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    test_done();
  end

  // Reset, then the scenarios in order
  initial begin
    {nrst_in, req_in, wr_in, long_active_in, code_long_in, swap_in} = '0;
    {cpl_in, page_attr_in, addr_in, phys_addr_in, wdata_in} = '0;
    repeat (16) @(negedge mclk_in);
    nrst_in = 1'b1;
    t_cfg();
    t_priv();
    t_link();
    t_type();
    t_top();
    test_done();
  end
endmodule : tb
